// [two_wire_pkg.sv]
// constants, register map and types of the two-wire serial channel
package two_wire_pkg;

  // ==========================================================================
  // bus and register map (printed offsets are word indexes)
  localparam int          ADDR_W          = 18;
  localparam logic [15:0] MODE_IDX        = 16'hff60;
  localparam logic [15:0] BUS_CTRL_IDX    = 16'hff61;
  localparam logic [15:0] TIMING_IDX      = 16'hff63;
  localparam logic [15:0] SHIFT_IDX       = 16'hff64;
  localparam logic [15:0] SLAVE_ADDR_IDX  = 16'hff65;
  localparam logic [15:0] STATUS_IDX      = 16'hff66;
  localparam logic [15:0] PORT_IDX        = 16'hff67;
  localparam logic [17:0] MODE_ADDR       = {MODE_IDX, 2'b00};
  localparam logic [17:0] BUS_CTRL_ADDR   = {BUS_CTRL_IDX, 2'b00};
  localparam logic [17:0] TIMING_ADDR     = {TIMING_IDX, 2'b00};
  localparam logic [17:0] SHIFT_ADDR      = {SHIFT_IDX, 2'b00};
  localparam logic [17:0] SLAVE_ADDR_ADDR = {SLAVE_ADDR_IDX, 2'b00};
  localparam logic [17:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};
  localparam logic [17:0] PORT_ADDR       = {PORT_IDX, 2'b00};

  // ==========================================================================
  // field positions
  localparam int MODE_ENABLE_BIT  = 7;
  localparam int MODE_MATCH_BIT   = 6;
  localparam int MODE_WAKE_BIT    = 5;
  localparam int MODE_SEL_HI_BIT  = 4;
  localparam int MODE_SEL_LO_BIT  = 3;
  localparam int MODE_PIN_A_BIT   = 2;
  localparam int MODE_INT_CLK_BIT = 1;
  localparam int BUS_ACK_BIT      = 4;
  localparam int BUS_START_BIT    = 3;
  localparam int BUS_STOP_BIT     = 2;
  localparam int BUS_CMD_BIT      = 1;
  localparam int BUS_REL_BIT      = 0;
  localparam int TIMING_LEVEL_BIT = 6;
  localparam int TIMING_SRC_BIT   = 5;
  localparam int STATUS_FLAG_BIT  = 0;
  localparam int PORT_LATCH_BIT   = 0;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam logic [7:0] TIMING_RESET     = 8'h00;
  localparam logic [7:0] SHIFT_RESET      = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
  localparam logic       PORT_RESET       = 1'b1;
  localparam logic [7:0] MODE_WR_MASK     = 8'hbf;
  localparam logic [7:0] TIMING_WR_MASK   = 8'h3f;

  // ==========================================================================
  // timing and pins
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         SCK_HALF_NS     = 2500;
  localparam logic [7:0] SCK_HALF_CYCLES = 8'(SCK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [3:0] LAST_BIT        = 4'h7;
  localparam int         NUM_PINS        = 3;
  localparam int         PIN_SCL         = 0;
  localparam int         PIN_SDA_A       = 1;
  localparam int         PIN_SDA_B       = 2;

  typedef enum logic {ST_IDLE, ST_SHIFT} xfer_state_type;

endpackage : two_wire_pkg

// [pin_sync.sv]
// three-stage pin synchroniser with debounced level and edge pulses
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_ff, s2_ff, s3_ff;

  // ==========================================================================
  // sampling chain; idle bus lines are pulled high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= (s2_ff == s3_ff) && s3_ff && !level;
      fall <= (s2_ff == s3_ff) && !s3_ff && level;
      if (s2_ff == s3_ff) begin
        level <= s3_ff;
      end
    end
  end

endmodule : pin_sync

// [two_wire_serial_channel.sv]
// two-wire serial channel: apb registers, byte shifter, bus conditions
//
// Functional notes
// - match flag is read-only, set when slave address equals shift data, reads zero while disabled
// - writing release trigger sets output latch, bit reads back zero
// - writing command trigger clears output latch, bit reads back zero
// - both triggers have no effect and read zero while disabled
// - source select: interrupt on transfer end (0) or bus release (1)
// - clock pin level is readable, reads zero while disabled
// - bytes are eight bits; shift-out happens on serial clock falling edge
// - output latch drives selected data pin, most significant bit first
// - received bit is captured into shift register on rising edge
// - after eight bits shifting halts and, with transfer-end source (0) selected, interrupt flag is set
// - shift write starts only when enabled and idle, with internal clock selected or clock pin high
// - shift write before enabling starts no transfer
// - with wake-up on, transfer-end interrupt only when received address matches
// - only master issues conditions; slave detects start and stop
// - receiver of a byte drives the acknowledge bit
// - seven bits after start form the address compared with slave address
`timescale 1ns/1ps
module two_wire_serial_channel
  import two_wire_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [two_wire_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     serial_clock_pin_sense,
  output logic                          serial_clock_pin_value,
  output logic                          serial_clock_pin_oe,
  input  wire logic                     data_pin_a_sense,
  output logic                          data_pin_a_value,
  output logic                          data_pin_a_oe,
  input  wire logic                     data_pin_b_sense,
  output logic                          data_pin_b_value,
  output logic                          data_pin_b_oe,
  output logic                          channel_interrupt_request
);
  import two_wire_pkg::*;

  logic                 rst_meta_ff, rst_sync_n_ff;
  logic [NUM_PINS-1:0]  pin_raw, pin_lvl, pin_rise, pin_fall;
  logic [7:0]           mode_ff, timing_ff, shift_ff, sva_ff, nxt_shift;
  logic [7:0]           sck_div_ff;
  logic [3:0]           bit_cnt_ff;
  logic [7:0]           rd_val;
  logic                 rd_hit, pready_ff, pslverr_ff, pin_low_ff;
  logic                 port_latch_ff, irq_flag_ff, so_latch_ff, ack_drive_ff;
  logic                 start_ff, stop_ff, sck_int_ff;
  logic                 scl_oe_ff, sda_a_oe_ff, sda_b_oe_ff;
  logic [31:0]          prdata_ff;
  xfer_state_type       state_ff;
  logic                 enable, wake, int_clk, pin_a_sel, two_wire_mode;
  logic                 sda_level, sda_rise, sda_fall, scl_level;
  logic                 scl_rise, scl_fall, done, wr_en, start_xfer;
  logic                 shifting, xfer_done, addr_match, sda_low, stop_set;

  // ==========================================================================
  // reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // pin sampling
  assign pin_raw = {data_pin_b_sense, data_pin_a_sense, serial_clock_pin_sense};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      pin_sync u_sync (
        .clk   (clk),
        .rst_n (rst_sync_n_ff),
        .din   (pin_raw[gi]),
        .level (pin_lvl[gi]),
        .rise  (pin_rise[gi]),
        .fall  (pin_fall[gi])
      );
    end
  endgenerate

  assign enable        = mode_ff[MODE_ENABLE_BIT];
  assign wake          = mode_ff[MODE_WAKE_BIT];
  assign int_clk       = mode_ff[MODE_INT_CLK_BIT];
  assign pin_a_sel     = mode_ff[MODE_PIN_A_BIT];
  assign two_wire_mode = mode_ff[MODE_SEL_HI_BIT] & mode_ff[MODE_SEL_LO_BIT];
  assign scl_level     = pin_lvl[PIN_SCL];
  assign scl_rise      = pin_rise[PIN_SCL];
  assign scl_fall      = pin_fall[PIN_SCL];
  assign sda_level = pin_a_sel ? pin_lvl[PIN_SDA_A]  : pin_lvl[PIN_SDA_B];
  assign sda_rise  = pin_a_sel ? pin_rise[PIN_SDA_A] : pin_rise[PIN_SDA_B];
  assign sda_fall  = pin_a_sel ? pin_fall[PIN_SDA_A] : pin_fall[PIN_SDA_B];

  // ==========================================================================
  // apb slave: one wait state, unmapped addresses answer with pslverr
  assign done  = psel & penable & pready_ff;
  assign wr_en = done & pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (paddr == MODE_ADDR) begin
      rd_val = mode_ff;
      rd_val[MODE_MATCH_BIT] = enable && (shift_ff == sva_ff);
    end else if (paddr == BUS_CTRL_ADDR) begin
      // trigger bits self-clear, so they always read zero
      rd_val = {3'h0, ack_drive_ff, start_ff, stop_ff, 2'h0};
    end else if (paddr == TIMING_ADDR) begin
      rd_val = timing_ff;
      rd_val[TIMING_LEVEL_BIT] = enable && scl_level;
    end else if (paddr == SHIFT_ADDR) begin
      rd_val = shift_ff;
    end else if (paddr == SLAVE_ADDR_ADDR) begin
      rd_val = sva_ff;
    end else if (paddr == STATUS_ADDR) begin
      rd_val = {7'h00, irq_flag_ff};
    end else if (paddr == PORT_ADDR) begin
      rd_val = {7'h00, port_latch_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel & penable & !pready_ff;
      pslverr_ff <= psel & penable & !pready_ff & !rd_hit;
      if (psel & penable & !pready_ff) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end
    end
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      mode_ff       <= MODE_RESET;
      timing_ff     <= TIMING_RESET;
      sva_ff        <= SLAVE_ADDR_RESET;
      port_latch_ff <= PORT_RESET;
    end else if (wr_en) begin
      if (paddr == MODE_ADDR) begin
        mode_ff <= pwdata[7:0] & MODE_WR_MASK;
      end else if (paddr == TIMING_ADDR) begin
        timing_ff <= pwdata[7:0] & TIMING_WR_MASK;
      end else if (paddr == SLAVE_ADDR_ADDR) begin
        sva_ff <= pwdata[7:0];
      end else if (paddr == PORT_ADDR) begin
        port_latch_ff <= pwdata[PORT_LATCH_BIT];
      end
    end
  end

  // ==========================================================================
  // transfer control
  // a write while the channel is off only loads the data; enabling later
  // does not launch it
  assign start_xfer = wr_en && (paddr == SHIFT_ADDR) && enable &&
                      (state_ff == ST_IDLE) && (int_clk || scl_level);
  assign shifting   = (state_ff == ST_SHIFT);
  assign xfer_done  = shifting && scl_rise && (bit_cnt_ff == LAST_BIT);
  assign nxt_shift  = {shift_ff[6:0], sda_level};
  // the eighth bit is the direction bit; only the seven ahead of it count
  assign addr_match = (nxt_shift[7:1] == sva_ff[7:1]);
  assign stop_set   = enable && scl_level && sda_rise;

  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bit_cnt_ff <= 4'h0;
          if (start_xfer) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!enable || xfer_done) begin
            state_ff <= ST_IDLE;
          end else if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // data is frozen during a byte so a stray write cannot corrupt it
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      shift_ff <= SHIFT_RESET;
    end else if (shifting) begin
      if (scl_rise) begin
        shift_ff <= nxt_shift;
      end
    end else if (wr_en && (paddr == SHIFT_ADDR)) begin
      shift_ff <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // output latch; wake-up keeps the data output released except for a software acknowledge
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      so_latch_ff <= 1'b1;
    end else if (start_xfer) begin
      so_latch_ff <= pwdata[7] | wake;
    end else if (shifting && scl_fall) begin
      so_latch_ff <= shift_ff[7] | wake;
    end else if (wr_en && (paddr == BUS_CTRL_ADDR) && enable) begin
      if (pwdata[BUS_CMD_BIT]) begin
        so_latch_ff <= 1'b0;
      end else if (pwdata[BUS_REL_BIT]) begin
        so_latch_ff <= 1'b1;
      end
    end
  end

  // software acknowledge: holds data low until the next clock fall
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      ack_drive_ff <= 1'b0;
    end else if (!enable) begin
      ack_drive_ff <= 1'b0;
    end else if (wr_en && (paddr == BUS_CTRL_ADDR) && pwdata[BUS_ACK_BIT]) begin
      ack_drive_ff <= 1'b1;
    end else if (scl_fall) begin
      ack_drive_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // start and stop detection; detection wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      start_ff <= 1'b0;
      stop_ff  <= 1'b0;
    end else if (!enable) begin
      start_ff <= 1'b0;
      stop_ff  <= 1'b0;
    end else begin
      if (start_xfer) begin
        start_ff <= 1'b0;
        stop_ff  <= 1'b0;
      end
      if (xfer_done && wake && start_ff && !addr_match) begin
        stop_ff <= 1'b0;
      end
      if (scl_level && sda_fall) begin
        start_ff <= 1'b1;
      end
      if (stop_set) begin
        stop_ff  <= 1'b1;
        start_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // interrupt flag; software clears by writing one, a new event wins
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      irq_flag_ff <= 1'b0;
    end else if (!timing_ff[TIMING_SRC_BIT] && xfer_done &&
                 (!wake || (start_ff && addr_match))) begin
      irq_flag_ff <= 1'b1;
    end else if (timing_ff[TIMING_SRC_BIT] && stop_set) begin
      irq_flag_ff <= 1'b1;
    end else if (wr_en && (paddr == STATUS_ADDR) &&
                 pwdata[STATUS_FLAG_BIT]) begin
      irq_flag_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // internal serial clock: eight low/high periods, idles high
  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      sck_div_ff <= 8'h00;
      sck_int_ff <= 1'b1;
    end else if (!(shifting && int_clk)) begin
      sck_div_ff <= 8'h00;
      sck_int_ff <= 1'b1;
    end else if (sck_div_ff == SCK_HALF_CYCLES - 8'h01) begin
      sck_div_ff <= 8'h00;
      sck_int_ff <= !sck_int_ff;
    end else begin
      sck_div_ff <= sck_div_ff + 8'h01;
    end
  end

  // ==========================================================================
  // open-drain pin drivers
  assign sda_low = (!so_latch_ff && !wake) || ack_drive_ff;

  always_ff @(posedge clk or negedge rst_sync_n_ff) begin
    if (!rst_sync_n_ff) begin
      scl_oe_ff   <= 1'b0;
      sda_a_oe_ff <= 1'b0;
      sda_b_oe_ff <= 1'b0;
      pin_low_ff  <= 1'b0;
    end else begin
      scl_oe_ff   <= enable && two_wire_mode && int_clk &&
                     (!sck_int_ff || !port_latch_ff);
      sda_a_oe_ff <= enable && two_wire_mode && pin_a_sel && sda_low;
      sda_b_oe_ff <= enable && two_wire_mode && !pin_a_sel && sda_low;
      pin_low_ff  <= 1'b0;
    end
  end

  assign prdata                    = prdata_ff;
  assign pready                    = pready_ff;
  assign pslverr                   = pslverr_ff;
  assign serial_clock_pin_value    = pin_low_ff;
  assign serial_clock_pin_oe       = scl_oe_ff;
  assign data_pin_a_value          = pin_low_ff;
  assign data_pin_a_oe             = sda_a_oe_ff;
  assign data_pin_b_value          = pin_low_ff;
  assign data_pin_b_oe             = sda_b_oe_ff;
  assign channel_interrupt_request = irq_flag_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n_ff);

  sequence bus_ctrl_write;
    wr_en && (paddr == BUS_CTRL_ADDR);
  endsequence

  sequence address_byte_miss;
    !irq_flag_ff && xfer_done && wake && !addr_match;
  endsequence

  chk_match_disabled: assert property (
    (psel && penable && !pready_ff && !pwrite && paddr == MODE_ADDR &&
     !enable) |=> !prdata_ff[MODE_MATCH_BIT])
    else $error("match flag read as one while disabled");

  chk_release_sets: assert property (
    (bus_ctrl_write and (enable && pwdata[0] && !pwdata[1] && !shifting))
    |=> so_latch_ff)
    else $error("release trigger did not set output latch");

  chk_command_clears: assert property (
    (bus_ctrl_write and (enable && pwdata[1] && !shifting)) |=> !so_latch_ff)
    else $error("command trigger did not clear output latch");

  chk_trigger_disabled: assert property (
    (bus_ctrl_write and !enable) |=> $stable(so_latch_ff))
    else $error("trigger acted while disabled");

  chk_irq_source: assert property (
    (xfer_done && !timing_ff[TIMING_SRC_BIT] && !wake) |=> irq_flag_ff)
    else $error("transfer end did not raise interrupt flag");

  chk_clock_level: assert property (
    (psel && penable && !pready_ff && !pwrite && paddr == TIMING_ADDR)
    |=> prdata_ff[TIMING_LEVEL_BIT] == $past(enable && scl_level))
    else $error("clock level read wrong");

  chk_shift_out: assert property (
    (shifting && scl_fall && !wake) |=> so_latch_ff == $past(shift_ff[7]))
    else $error("output latch did not take the next bit");

  chk_capture_rise: assert property (
    (shifting && scl_rise) |=> shift_ff[0] == $past(sda_level))
    else $error("received bit not captured on rising edge");

  chk_byte_end: assert property (
    xfer_done |=> (state_ff == ST_IDLE) ##1 (state_ff == ST_IDLE))
    else $error("shifting did not halt after eight bits");

  chk_start_gate: assert property (
    (state_ff == ST_IDLE && wr_en && paddr == SHIFT_ADDR && !enable)
    |=> state_ff == ST_IDLE)
    else $error("transfer started while disabled");

  chk_wake_filter: assert property (
    address_byte_miss |=> !irq_flag_ff)
    else $error("interrupt on mismatched address");

  chk_open_drain: assert property (
    (so_latch_ff && !ack_drive_ff) |=> !data_pin_a_oe && !data_pin_b_oe)
    else $error("data pin driven while latch holds one");

endmodule : two_wire_serial_channel

// [bus_peer.sv]
// far-side peer on the two-wire bus: sends one byte open-drain
`timescale 1ns/1ps
module bus_peer (
  input  wire logic       scl,
  input  wire logic       talk,
  input  wire logic [7:0] send_byte,
  output logic            pull_low
);
  logic [7:0] sh;
  logic       armed;
  // =========================================================================
  // sender
  // the first fall comes before any rise, so bit 7 stands across it
  always @(posedge scl or negedge talk) armed = (talk === 1'b1);
  always @(negedge scl) sh = armed ? {sh[6:0], 1'b1} : send_byte;
  // released line goes to the pull-up level, never holds the last bit
  assign pull_low = talk & ~(armed ? sh[7] : send_byte[7]);
endmodule : bus_peer

// [two_wire_serial_channel_tb_top.sv]
// register-level testbench of the two-wire serial channel
`timescale 1ns/1ps
module two_wire_serial_channel_tb_top;
  import two_wire_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, talk;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, scl_oe, sda_oe, pull_low, irq, err_q;
  logic [7:0]  wire_sh;
  int          n_errors, checks;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | pull_low);
  two_wire_serial_channel two_wire_serial_channel_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin_sense(scl),
    .serial_clock_pin_value(), .serial_clock_pin_oe(scl_oe),
    .data_pin_a_sense(sda), .data_pin_a_value(), .data_pin_a_oe(sda_oe),
    .data_pin_b_sense(1'b1), .data_pin_b_value(), .data_pin_b_oe(),
    .channel_interrupt_request(irq));
  bus_peer bus_peer_inst (.scl(scl), .talk(talk), .send_byte(8'h3c),
    .pull_low(pull_low));
  // the wire is sampled where the receiver samples it
  always @(posedge scl) wire_sh <= {wire_sh[6:0], sda};
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // =========================================================================
  // tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    err_q = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic wait_irq;
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(posedge clk);
  endtask : wait_irq
  // start condition comes from the peer while the internal clock is high
  task automatic wake_rx(input logic [7:0] e);
    wr(MODE_ADDR, 8'h9e);
    wr(SHIFT_ADDR, 8'hff);
    wr(MODE_ADDR, 8'hbe);
    talk <= 1'b1;
    wait_irq;
    chk({7'h0, irq}, e);
    talk <= 1'b0;
    @(posedge clk);
  endtask : wake_rx
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // =========================================================================
  // tests
  initial begin
    #(25 * 40000);
    n_errors++;
    complete_run;
  end
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; talk = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(BUS_CTRL_ADDR, 8'h00);
    rd(TIMING_ADDR, 8'h00);
    rd(18'h00000, 8'h00);
    chk({7'h0, err_q}, 8'h01);
    wr(SHIFT_ADDR, 8'h5a);
    wr(MODE_ADDR, 8'h9e);
    repeat (300) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    rd(TIMING_ADDR, 8'h40);
    wr(PORT_ADDR, 8'h00);
    repeat (8) @(posedge clk);
    rd(TIMING_ADDR, 8'h00);
    wr(PORT_ADDR, 8'h01);
    $display("test reset and enable done");
    wr(BUS_CTRL_ADDR, 8'h02);
    @(posedge clk);
    chk({7'h0, sda_oe}, 8'h01);
    repeat (4) @(posedge clk);
    rd(BUS_CTRL_ADDR, 8'h08);
    wr(BUS_CTRL_ADDR, 8'h01);
    @(posedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    $display("test triggers done");
    wr(SLAVE_ADDR_ADDR, 8'ha5);
    wr(SHIFT_ADDR, 8'ha5);
    wait_irq;
    chk({7'h0, irq}, 8'h01);
    chk(wire_sh, 8'ha5);
    rd(SHIFT_ADDR, 8'ha5);
    rd(MODE_ADDR, 8'hde);
    wr(STATUS_ADDR, 8'h01);
    $display("test transmit done");
    talk <= 1'b1;
    wr(SHIFT_ADDR, 8'hff);
    wait_irq;
    rd(SHIFT_ADDR, 8'h3c);
    rd(MODE_ADDR, 8'h9e);
    wr(STATUS_ADDR, 8'h01);
    wr(TIMING_ADDR, 8'h20);
    talk <= 1'b0;
    wait_irq;
    chk({7'h0, irq}, 8'h01);
    rd(BUS_CTRL_ADDR, 8'h04);
    wr(TIMING_ADDR, 8'h00);
    wr(STATUS_ADDR, 8'h01);
    $display("test receive done");
    wake_rx(8'h00);
    wr(SLAVE_ADDR_ADDR, 8'h3d);
    wake_rx(8'h01);
    wr(STATUS_ADDR, 8'h01);
    $display("test wake-up done");
    wr(MODE_ADDR, 8'h00);
    wr(BUS_CTRL_ADDR, 8'h02);
    rd(TIMING_ADDR, 8'h00);
    rd(MODE_ADDR, 8'h00);
    wr(MODE_ADDR, 8'h9e);
    @(posedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    $display("test disable done");
    complete_run;
  end
endmodule : two_wire_serial_channel_tb_top
